// >>> nibble_xfer_pkg.sv
// Package holding opcodes, widths and reset values for the transfer unit
package nibble_xfer_pkg;

  // ****************************************************************
  // Data widths
  // ****************************************************************
  localparam int NIB_W = 4;  // Accumulator, B, X, Y width
  localparam int D_W   = 3;  // Register D width
  localparam int Z_W   = 2;  // Register Z width
  localparam int SP_W  = 3;  // Stack pointer width
  localparam int E_W   = 8;  // Register E width
  localparam int DP_W  = 10; // Data pointer: Z, X, Y
  localparam int OPC_W = 5;  // Operation select width

  // ****************************************************************
  // Reset values and skip compare values
  // ****************************************************************
  localparam logic [3:0] NIB_RST  = 4'h0;
  localparam logic [2:0] D_RST    = 3'h0;
  localparam logic [1:0] Z_RST    = 2'h0;
  localparam logic [7:0] E_RST    = 8'h00;
  localparam logic [3:0] NIB_ONE  = 4'h1;
  localparam logic [3:0] Y_WRAP_UP = 4'h0; // Result after increment wrap
  localparam logic [3:0] Y_WRAP_DN = 4'hF; // Result after decrement wrap

  // ****************************************************************
  // Operation select codes on the OP port
  // ****************************************************************
  localparam logic [4:0] OP_NOP      = 5'h00;
  localparam logic [4:0] OP_B_TO_ACC = 5'h01;
  localparam logic [4:0] OP_ACC_TO_B = 5'h02;
  localparam logic [4:0] OP_Y_TO_ACC = 5'h03;
  localparam logic [4:0] OP_ACC_TO_Y = 5'h04;
  localparam logic [4:0] OP_PACK_E   = 5'h05;
  localparam logic [4:0] OP_UNPACK_E = 5'h06;
  localparam logic [4:0] OP_ACC_TO_D = 5'h07;
  localparam logic [4:0] OP_D_TO_ACC = 5'h08;
  localparam logic [4:0] OP_Z_TO_ACC = 5'h09;
  localparam logic [4:0] OP_X_TO_ACC = 5'h0A;
  localparam logic [4:0] OP_RD_SP    = 5'h0B;
  localparam logic [4:0] OP_LD_PAIR  = 5'h0C;
  localparam logic [4:0] OP_LD_Z     = 5'h0D;
  localparam logic [4:0] OP_INC_Y    = 5'h0E;
  localparam logic [4:0] OP_DEC_Y    = 5'h0F;
  localparam logic [4:0] OP_MEM_RD   = 5'h10;
  localparam logic [4:0] OP_MEM_XCH  = 5'h11;
  localparam logic [4:0] OP_MEM_XCHD = 5'h12;
  localparam logic [4:0] OP_MEM_XCHI = 5'h13;
  localparam logic [4:0] OP_MEM_WR   = 5'h14;

endpackage

// >>> nibble_transfer_exec_unit.sv
// Execution unit for register, RAM-address and RAM transfer instructions
`timescale 1ns/1ns

module nibble_transfer_exec_unit (
  input  wire logic       CLK,       // Core clock, 10 MHz
  input  wire logic       RST_B,     // Asynchronous reset, active low
  input  wire logic       EXEC,      // One instruction presented this cycle
  input  wire logic [4:0] OP,        // Decoded operation select
  input  wire logic [3:0] IMM_A,     // Immediate x, z or j
  input  wire logic [3:0] IMM_B,     // Immediate y
  input  wire logic [2:0] STACK_PTR, // Stack pointer from the core
  input  wire logic       CARRY_IN,  // Carry flag from the core
  input  wire logic [3:0] RAM_RDATA, // Nibble at the data pointer
  output logic      [3:0] ACC,       // Accumulator
  output logic      [3:0] REG_B,     // Register B
  output logic      [3:0] REG_X,     // Register X
  output logic      [3:0] REG_Y,     // Register Y
  output logic      [1:0] REG_Z,     // Register Z
  output logic      [2:0] REG_D,     // Register D
  output logic      [7:0] REG_E,     // Register E
  output logic      [9:0] RAM_ADDR,  // Data pointer address
  output logic      [3:0] RAM_WDATA, // Nibble to store
  output logic            RAM_WE,    // RAM write strobe
  output logic            CARRY_OUT, // Carry flag back to the core
  output logic            SKIP_NEXT  // Next instruction is suppressed
);

  // ****************************************************************
  // Overview
  // ****************************************************************
  // One instruction is offered per EXEC cycle and lands at the next edge.
  // A skipped slot is still consumed, so the core's fetch never stalls.
  // RAM writes leave one cycle late through a registered strobe; the
  // external RAM must not be read for an exchange in that cycle, since
  // the address then shows the pending write target.
  // OP codes outside the package list fall through with no effect.

  // ****************************************************************
  // State
  // ****************************************************************
  logic [3:0] acc_q;        // Accumulator
  logic [3:0] b_q;          // Register B
  logic [3:0] x_q;          // Register X
  logic [3:0] y_q;          // Register Y
  logic [1:0] z_q;          // Register Z
  logic [2:0] d_q;          // Register D
  logic [7:0] e_q;          // Register E
  logic       skip_q;       // Current instruction is suppressed
  logic       pair_run_q;   // Previous EXEC slot carried a pair load, skipped or not
  logic [3:0] wdata_q;      // Registered RAM write data
  logic       we_q;         // Registered RAM write strobe

  // ****************************************************************
  // Qualifiers
  // ****************************************************************
  logic       act;          // Instruction takes effect
  logic [3:0] y_inc;        // Y plus one, wraps modulo 16
  logic [3:0] y_dec;        // Y minus one, wraps modulo 16
  logic [3:0] x_xor;        // X xor immediate j
  logic       skip_d;       // Skip for the following instruction
  logic       pair_hold;    // Pair load right after a pair load

  // A pair load straight after another pair load is treated as skipped;
  // only the first of a run sets X and Y
  assign pair_hold = pair_run_q
                  && (OP == nibble_xfer_pkg::OP_LD_PAIR);

  // Skipped slots are fetched but change nothing
  assign act   = EXEC && !skip_q && !pair_hold;
  assign y_inc = 4'(y_q + nibble_xfer_pkg::NIB_ONE);
  assign y_dec = 4'(y_q - nibble_xfer_pkg::NIB_ONE);
  assign x_xor = x_q ^ IMM_A;

  // ****************************************************************
  // Skip decision
  // ****************************************************************
  // Computed from the pre-update Y so the test matches the new value
  always_comb begin
    skip_d = 1'b0;
    if (act) begin
      unique case (OP)
        nibble_xfer_pkg::OP_INC_Y,
        nibble_xfer_pkg::OP_MEM_XCHI: begin
          skip_d = (y_inc == nibble_xfer_pkg::Y_WRAP_UP);
        end
        nibble_xfer_pkg::OP_DEC_Y,
        nibble_xfer_pkg::OP_MEM_XCHD: begin
          skip_d = (y_dec == nibble_xfer_pkg::Y_WRAP_DN);
        end
        default: begin
          skip_d = 1'b0; // Other codes never skip
        end
      endcase
    end
  end

  // Skip flag: armed by an increment or decrement that wraps.
  // Runs of pair loads are held off by pair_hold instead, so a skip
  // never leaks past the run into the next real instruction.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      skip_q <= 1'b0;
    end else if (EXEC) begin
      // A skipped slot clears the flag; only one instruction is lost
      skip_q <= skip_d;
    end
  end

  // Pair-load run tracker: a run of pair loads keeps only the first
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pair_run_q <= 1'b0;
    end else if (EXEC) begin
      // Held through the run even while skipped slots go by
      pair_run_q <= (OP == nibble_xfer_pkg::OP_LD_PAIR);
    end
  end

  // ****************************************************************
  // Accumulator
  // ****************************************************************
  // Carry is never written by this group; it passes straight through
  // RAM read data is taken as it stands on RAM_ADDR, the live address unless a write is pending
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      acc_q <= nibble_xfer_pkg::NIB_RST;
    end else if (act) begin
      unique case (OP)
        nibble_xfer_pkg::OP_B_TO_ACC: begin
          acc_q <= b_q;
        end
        nibble_xfer_pkg::OP_Y_TO_ACC: begin
          acc_q <= y_q;
        end
        nibble_xfer_pkg::OP_UNPACK_E: begin
          acc_q <= e_q[3:0];
        end
        nibble_xfer_pkg::OP_D_TO_ACC: begin
          acc_q <= {1'b0, d_q};
        end
        nibble_xfer_pkg::OP_Z_TO_ACC: begin
          acc_q <= {2'b00, z_q};
        end
        nibble_xfer_pkg::OP_X_TO_ACC: begin
          acc_q <= x_q;
        end
        nibble_xfer_pkg::OP_RD_SP: begin
          acc_q <= {1'b0, STACK_PTR};
        end
        nibble_xfer_pkg::OP_MEM_RD,
        nibble_xfer_pkg::OP_MEM_XCH,
        nibble_xfer_pkg::OP_MEM_XCHD,
        nibble_xfer_pkg::OP_MEM_XCHI: begin
          acc_q <= RAM_RDATA;
        end
        default: begin
          acc_q <= acc_q; // Accumulator not a target
        end
      endcase
    end
  end

  // ****************************************************************
  // Register B
  // ****************************************************************
  // B: plain move from the accumulator or high half of E
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      b_q <= nibble_xfer_pkg::NIB_RST;
    end else if (act) begin
      if (OP == nibble_xfer_pkg::OP_ACC_TO_B) begin
        b_q <= acc_q;
      end else if (OP == nibble_xfer_pkg::OP_UNPACK_E) begin
        b_q <= e_q[7:4];
      end
    end
  end

  // ****************************************************************
  // Registers X and Y
  // ****************************************************************
  // X: pair load or xor update after the RAM access
  // The xor uses X as it was, so this cycle's RAM address is unaffected
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      x_q <= nibble_xfer_pkg::NIB_RST;
    end else if (act) begin
      unique case (OP)
        nibble_xfer_pkg::OP_LD_PAIR: begin
          x_q <= IMM_A;
        end
        nibble_xfer_pkg::OP_MEM_RD,
        nibble_xfer_pkg::OP_MEM_XCH,
        nibble_xfer_pkg::OP_MEM_XCHD,
        nibble_xfer_pkg::OP_MEM_XCHI,
        nibble_xfer_pkg::OP_MEM_WR: begin
          x_q <= x_xor;
        end
        default: begin
          x_q <= x_q; // X not a target
        end
      endcase
    end
  end

  // Y: moves, pair load, step up or down
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      y_q <= nibble_xfer_pkg::NIB_RST;
    end else if (act) begin
      unique case (OP)
        nibble_xfer_pkg::OP_ACC_TO_Y: begin
          y_q <= acc_q;
        end
        nibble_xfer_pkg::OP_LD_PAIR: begin
          y_q <= IMM_B;
        end
        nibble_xfer_pkg::OP_INC_Y,
        nibble_xfer_pkg::OP_MEM_XCHI: begin
          y_q <= y_inc;
        end
        nibble_xfer_pkg::OP_DEC_Y,
        nibble_xfer_pkg::OP_MEM_XCHD: begin
          y_q <= y_dec;
        end
        default: begin
          y_q <= y_q; // Y not a target
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers Z, D and E
  // ****************************************************************
  // Z: only the low two bits of the immediate are kept
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      z_q <= nibble_xfer_pkg::Z_RST;
    end else if (act && OP == nibble_xfer_pkg::OP_LD_Z) begin
      z_q <= IMM_A[1:0];
    end
  end

  // Bit 3 of the accumulator is dropped on purpose
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      d_q <= nibble_xfer_pkg::D_RST;
    end else if (act && OP == nibble_xfer_pkg::OP_ACC_TO_D) begin
      d_q <= acc_q[2:0];
    end
  end

  // Both nibbles of E change in the same edge
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      e_q <= nibble_xfer_pkg::E_RST;
    end else if (act && OP == nibble_xfer_pkg::OP_PACK_E) begin
      e_q <= {b_q, acc_q};
    end
  end

  // ****************************************************************
  // RAM write side
  // ****************************************************************
  // Write is registered one cycle; address uses pre-xor X of that cycle,
  // so the address is captured alongside to stay aligned
  logic [9:0] waddr_q; // Address for the registered write

  // Write strobe: one pulse for every executed store or exchange
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      we_q <= 1'b0;
    end else begin
      we_q <= act && (OP == nibble_xfer_pkg::OP_MEM_WR
                   || OP == nibble_xfer_pkg::OP_MEM_XCH
                   || OP == nibble_xfer_pkg::OP_MEM_XCHD
                   || OP == nibble_xfer_pkg::OP_MEM_XCHI);
    end
  end

  // Write data: the accumulator as it stood before the instruction,
  // which is what an exchange must leave behind in RAM
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wdata_q <= nibble_xfer_pkg::NIB_RST;
    end else begin
      wdata_q <= acc_q;
    end
  end

  // Write address: captured before X takes its xor update
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      waddr_q <= {nibble_xfer_pkg::Z_RST, nibble_xfer_pkg::NIB_RST,
                  nibble_xfer_pkg::NIB_RST};
    end else begin
      waddr_q <= {z_q, x_q, y_q};
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Read address is live; a pending write presents its captured address
  assign RAM_ADDR  = we_q ? waddr_q : {z_q, x_q, y_q};
  assign RAM_WDATA = wdata_q;
  assign RAM_WE    = we_q;
  // Carry passes straight through; no instruction here writes it
  assign CARRY_OUT = CARRY_IN;
  // Skip is shown to the core so its fetch can discard the next slot
  assign SKIP_NEXT = skip_q;
  // Architectural registers are shown straight from their flip-flops
  assign ACC       = acc_q;
  assign REG_B     = b_q;
  assign REG_X     = x_q;
  assign REG_Y     = y_q;
  assign REG_Z     = z_q;
  assign REG_D     = d_q;
  assign REG_E     = e_q;

endmodule

// >>> nibble_xfer_chk.sv
// Port checker for the nibble transfer execution unit
`timescale 1ns/1ns

module nibble_xfer_chk (
  input wire logic       CLK,
  input wire logic       RST_B,
  input wire logic       EXEC,
  input wire logic [4:0] OP,
  input wire logic       CARRY_IN,
  input wire logic [3:0] ACC,
  input wire logic [3:0] REG_B,
  input wire logic [3:0] REG_X,
  input wire logic [3:0] REG_Y,
  input wire logic [1:0] REG_Z,
  input wire logic [2:0] REG_D,
  input wire logic [7:0] REG_E,
  input wire logic [9:0] RAM_ADDR,
  input wire logic [3:0] RAM_WDATA,
  input wire logic       RAM_WE,
  input wire logic       CARRY_OUT,
  input wire logic       SKIP_NEXT
);
  // ****************************************************************
  // Helper and clocking
  // ****************************************************************
  logic go;  // An instruction executes in this slot, unless it is a held pair load
  assign go = EXEC && !SKIP_NEXT;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_carry_kept: assert property (
    CARRY_OUT == CARRY_IN)
    else $error("carry flag altered");
  a_b_to_acc: assert property (
    go && OP == nibble_xfer_pkg::OP_B_TO_ACC
    |=> ACC == $past(REG_B) && $stable(REG_B))
    else $error("b to acc");
  a_pack_e: assert property (
    go && OP == nibble_xfer_pkg::OP_PACK_E
    |=> REG_E == {$past(REG_B), $past(ACC)})
    else $error("pack e");
  a_d_to_acc: assert property (
    go && OP == nibble_xfer_pkg::OP_D_TO_ACC
    |=> ACC == {1'b0, $past(REG_D)})
    else $error("d to acc");
  a_inc_skip: assert property (
    go && OP == nibble_xfer_pkg::OP_INC_Y
    |=> REG_Y == $past(REG_Y) + 4'h1 && SKIP_NEXT == (REG_Y == 4'h0))
    else $error("increment skip");
  a_dec_skip: assert property (
    go && OP == nibble_xfer_pkg::OP_DEC_Y
    |=> REG_Y == $past(REG_Y) - 4'h1 && SKIP_NEXT == (REG_Y == 4'hF))
    else $error("decrement skip");
  a_write_pulse: assert property (
    go && OP == nibble_xfer_pkg::OP_MEM_WR
    |=> RAM_WE && RAM_WDATA == $past(ACC)
    && RAM_ADDR == {$past(REG_Z), $past(REG_X), $past(REG_Y)})
    else $error("memory write");
  a_skip_frozen: assert property (
    EXEC && SKIP_NEXT
    |=> $stable(ACC) && $stable(REG_X) && $stable(REG_Y) && !RAM_WE)
    else $error("skipped slot had effect");
  // Only the first of a run of pair loads may touch X and Y
  a_pair_run: assert property (
    (go && OP == nibble_xfer_pkg::OP_LD_PAIR)
    ##1 (EXEC && OP == nibble_xfer_pkg::OP_LD_PAIR)
    |=> $stable(REG_X) && $stable(REG_Y))
    else $error("pair run executed");

  c_inc_skip: cover property (
    (go && OP == nibble_xfer_pkg::OP_INC_Y) ##1 SKIP_NEXT);
  c_write: cover property (RAM_WE);
  c_pair_run: cover property (
    (go && OP == nibble_xfer_pkg::OP_LD_PAIR)
    ##1 (EXEC && OP == nibble_xfer_pkg::OP_LD_PAIR));
endmodule

bind nibble_transfer_exec_unit nibble_xfer_chk u_nibble_xfer_chk (
  .CLK(CLK), .RST_B(RST_B), .EXEC(EXEC), .OP(OP), .CARRY_IN(CARRY_IN),
  .ACC(ACC), .REG_B(REG_B), .REG_X(REG_X), .REG_Y(REG_Y), .REG_Z(REG_Z),
  .REG_D(REG_D), .REG_E(REG_E), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA),
  .RAM_WE(RAM_WE), .CARRY_OUT(CARRY_OUT), .SKIP_NEXT(SKIP_NEXT));

// >>> tb_top.sv
// Self-checking testbench for the nibble transfer execution unit
`timescale 1ns/1ns

module tb_top;
  logic       clk = 1'b0;   // 10 MHz core clock
  logic       rst_b = 1'b0; // Reset, active low
  logic       exec = 1'b0;
  logic [4:0] opc = 5'h00;
  logic [3:0] imm_a = 4'h0;
  logic [3:0] imm_b = 4'h0;
  logic [2:0] sp = 3'h7;    // Stack pointer, fixed
  logic       cy = 1'b1;    // Carry in, low in one scenario
  logic [3:0] acc, rb, rx, ry, wd, rdat;
  logic [1:0] rz;
  logic [2:0] rd;
  logic [7:0] re;
  logic [9:0] addr;
  logic       we, cy_o, skip;
  logic [3:0] mem [1024];   // Data RAM, read without delay
  int         fails = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  assign rdat = mem[addr];
  always #50 clk = ~clk;
  // RAM takes a write on the edge that ends the strobe cycle
  always @(posedge clk) begin
    if (we === 1'b1)
      mem[addr] <= wd;
  end
  // Hang guard, far above the length of the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      summarize();
    end
  end

  nibble_transfer_exec_unit u_nibble_transfer_exec_unit (
    .CLK(clk), .RST_B(rst_b), .EXEC(exec), .OP(opc), .IMM_A(imm_a),
    .IMM_B(imm_b), .STACK_PTR(sp), .CARRY_IN(cy), .RAM_RDATA(rdat),
    .ACC(acc), .REG_B(rb), .REG_X(rx), .REG_Y(ry), .REG_Z(rz), .REG_D(rd),
    .REG_E(re), .RAM_ADDR(addr), .RAM_WDATA(wd), .RAM_WE(we),
    .CARRY_OUT(cy_o), .SKIP_NEXT(skip));

  // ****************************************************************
  // Drivers and compare
  // ****************************************************************
  // Holds the slot up; the next call may follow at the same step
  task automatic issue(input logic [4:0] op, input logic [3:0] a, b);
    exec = 1'b1;
    opc = op;
    imm_a = a;
    imm_b = b;
    @(posedge clk);
    #1;
  endtask
  task automatic idle();
    exec = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_moves();
    mem[10'h2A5] = 4'h9;
    issue(nibble_xfer_pkg::OP_LD_PAIR, 4'hA, 4'h5);
    chk({rx, ry}, 8'hA5);
    issue(nibble_xfer_pkg::OP_LD_Z, 4'h2, 4'h0);
    chk(rz, 2'h2);
    issue(nibble_xfer_pkg::OP_MEM_RD, 4'h6, 4'h0);
    chk({acc, rx}, 8'h9C);
    issue(nibble_xfer_pkg::OP_ACC_TO_B, 4'h0, 4'h0);
    chk(rb, 4'h9);
    issue(nibble_xfer_pkg::OP_Y_TO_ACC, 4'h0, 4'h0);
    chk(acc, 4'h5);
    issue(nibble_xfer_pkg::OP_PACK_E, 4'h0, 4'h0);
    chk(re, 8'h95);
    issue(nibble_xfer_pkg::OP_X_TO_ACC, 4'h0, 4'h0);
    chk(acc, 4'hC);
    issue(nibble_xfer_pkg::OP_ACC_TO_Y, 4'h0, 4'h0);
    chk(ry, 4'hC);
    issue(nibble_xfer_pkg::OP_B_TO_ACC, 4'h0, 4'h0);
    chk({acc, rb}, 8'h99);
    issue(nibble_xfer_pkg::OP_ACC_TO_D, 4'h0, 4'h0);
    chk(rd, 3'h1);
    issue(nibble_xfer_pkg::OP_Z_TO_ACC, 4'h0, 4'h0);
    chk(acc, 4'h2);
    issue(nibble_xfer_pkg::OP_D_TO_ACC, 4'h0, 4'h0);
    chk(acc, 4'h1);
    issue(nibble_xfer_pkg::OP_RD_SP, 4'h0, 4'h0);
    chk(acc, 4'h7);
    issue(nibble_xfer_pkg::OP_ACC_TO_B, 4'h0, 4'h0);
    issue(nibble_xfer_pkg::OP_UNPACK_E, 4'h0, 4'h0);
    chk({rb, acc}, 8'h95);
    chk(cy_o, 1'b1);
    idle();
  endtask

  task automatic t_skip();
    cy = 1'b0;
    issue(nibble_xfer_pkg::OP_LD_PAIR, 4'h1, 4'hF);
    issue(nibble_xfer_pkg::OP_LD_PAIR, 4'h2, 4'h3);
    chk({rx, ry}, 8'h1F);
    chk(skip, 1'b0);
    idle();
    issue(nibble_xfer_pkg::OP_INC_Y, 4'h0, 4'h0);
    chk({ry, 3'h0, skip}, 8'h01);
    issue(nibble_xfer_pkg::OP_ACC_TO_Y, 4'h0, 4'h0);
    chk({ry, 3'h0, skip}, 8'h00);
    issue(nibble_xfer_pkg::OP_INC_Y, 4'h0, 4'h0);
    chk({ry, 3'h0, skip}, 8'h10);
    issue(nibble_xfer_pkg::OP_DEC_Y, 4'h0, 4'h0);
    chk({ry, 3'h0, skip}, 8'h00);
    issue(nibble_xfer_pkg::OP_DEC_Y, 4'h0, 4'h0);
    chk({ry, 3'h0, skip}, 8'hF1);
    issue(nibble_xfer_pkg::OP_LD_Z, 4'h3, 4'h0);
    chk(rz, 2'h2);
    chk(cy_o, 1'b0);
    cy = 1'b1;
    idle();
  endtask

  task automatic t_mem();
    mem[10'h160] = 4'hB;
    mem[10'h10F] = 4'h3;
    mem[10'h110] = 4'hD;
    issue(nibble_xfer_pkg::OP_LD_PAIR, 4'h3, 4'h0);
    issue(nibble_xfer_pkg::OP_LD_Z, 4'h1, 4'h0);
    issue(nibble_xfer_pkg::OP_Y_TO_ACC, 4'h0, 4'h0);
    issue(nibble_xfer_pkg::OP_MEM_WR, 4'h5, 4'h0);
    chk({we, addr, wd, rx}, {1'b1, 10'h130, 4'h0, 4'h6});
    idle();
    issue(nibble_xfer_pkg::OP_MEM_XCHD, 4'h6, 4'h0);
    chk({we, addr, wd, acc}, {1'b1, 10'h160, 4'h0, 4'hB});
    chk({rx, ry, 3'h0, skip}, 12'h0F1);
    issue(nibble_xfer_pkg::OP_X_TO_ACC, 4'h0, 4'h0);
    chk(acc, 4'hB);
    idle();
    issue(nibble_xfer_pkg::OP_MEM_XCHI, 4'h1, 4'h0);
    chk({we, addr, wd, acc}, {1'b1, 10'h10F, 4'hB, 4'h3});
    chk({rx, ry, 3'h0, skip}, 12'h101);
    issue(nibble_xfer_pkg::OP_MEM_WR, 4'hF, 4'h0);
    chk({we, rx}, 5'h01);
    idle();
    issue(nibble_xfer_pkg::OP_MEM_XCH, 4'h2, 4'h0);
    chk({we, addr, wd, acc}, {1'b1, 10'h110, 4'h3, 4'hD});
    chk({rx, 3'h0, skip}, 8'h30);
    idle();
    chk(mem[10'h110], 4'h3);
  endtask

  initial begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 4'h0;
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk({re, acc}, 12'h000);
    t_moves();
    t_skip();
    t_mem();
    summarize();
  end
endmodule
